// [src/wake_bus_pkg.sv]
// Constants for the wake and bus control register bank.
// Operation
// R1: Reserved bits of all four registers read back as zero.
// R2: Internal wake bit 6 enables the cyclic timer wake source.
// R3: Bits 5:4 pick battery threshold; 00 is highest, 01 to 11 are one to three.
// R4: Bit 2 disables the watchdog in stop mode; hardware may also update it.
// R5: Internal wake bit 0 enables fast battery voltage monitoring.
// R6: Power-on or soft reset loads 0x01 into both wake control registers.
// R7: Restart clears internal wake bits 7 and 3:1, keeping the rest.
// R8: External wake bit 0 enables the wake pin; hardware may update it.
// R9: Restart clears external wake bits 7:1 and keeps bit 0.
// R10: Fail-safe entry forces the external wake register to 0x01.
// R11: Pull field 1:0 selects none, pull-down, pull-up or automatic switching.
// R12: Restart clears pull register bits 7:2 and keeps the pull field.
// R13: Bus register bits 4:3 and 1:0 are channel modes: off, wake, receive, normal.
// R14: Bits 7 and 6 enable flash mode, removing slew control, for channels 2 and 1.
// R15: Restart clears bus bits 5 and 2, keeps flash, and adjusts channel modes.
// R16: Fail-safe entry reconfigures bus and wake registers so wake-up stays possible.
// R17: The other stop-mode watchdog bit means the same: set deactivates the watchdog.
// R18: Writes to reserved bits have no effect and those bits stay zero.
package wake_bus_pkg;
  localparam logic [5:0] IDX_INT_WAKE = 6'h06;
  localparam logic [5:0] IDX_EXT_WAKE = 6'h07;
  localparam logic [5:0] IDX_PULL = 6'h08;
  localparam logic [5:0] IDX_BUS2 = 6'h0A;

  localparam int BIT_CYCLIC = 6;
  localparam int BIT_THR_HI = 5;
  localparam int BIT_THR_LO = 4;
  localparam int BIT_WD_HI = 2;
  localparam int BIT_FAST_MON = 0;
  localparam int BIT_WAKE_PIN = 0;
  localparam int BIT_PULL_HI = 1;
  localparam int BIT_PULL_LO = 0;
  localparam int BIT_FLASH2 = 7;
  localparam int BIT_FLASH1 = 6;
  localparam int BIT_CH2_HI = 4;
  localparam int BIT_CH2_LO = 3;
  localparam int BIT_CH1_HI = 1;
  localparam int BIT_CH1_LO = 0;

  localparam logic [7:0] WMASK_INT_WAKE = 8'h75;
  localparam logic [7:0] WMASK_EXT_WAKE = 8'h01;
  localparam logic [7:0] WMASK_PULL = 8'h03;
  localparam logic [7:0] WMASK_BUS2 = 8'hDB;

  localparam logic [7:0] RST_INT_WAKE = 8'h01;
  localparam logic [7:0] RST_EXT_WAKE = 8'h01;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_BUS2 = 8'h00;

  localparam logic [7:0] KEEP_INT_WAKE = 8'h71;
  localparam logic [7:0] KEEP_EXT_WAKE = 8'h01;
  localparam logic [7:0] KEEP_PULL = 8'h03;
  localparam logic [7:0] KEEP_BUS2 = 8'hC0;

  localparam logic [7:0] FAILSAFE_EXT_WAKE = 8'h01;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RX_ONLY = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
endpackage

// [src/wake_and_bus_control_regs.sv]
// Wishbone register bank for wake sources, battery monitor and two bus channels.
//
// Decided for this implementation: the Wishbone interface to the registers.
module wake_and_bus_control_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic hw_wd_stop_wr_i,
  input wire logic hw_wd_stop_val_i,
  input wire logic hw_wake_pin_wr_i,
  input wire logic hw_wake_pin_val_i,
  input wire logic hw_mode_wr_i,
  input wire logic [1:0] hw_channel1_mode_i,
  input wire logic [1:0] hw_channel2_mode_i,
  input wire logic watchdog_stop_disable_lo_i,
  output logic cyclic_wake_enable_o,
  output logic [1:0] battery_threshold_select_o,
  output logic watchdog_stop_disable_hi_o,
  output logic watchdog_stop_off_o,
  output logic fast_battery_monitor_enable_o,
  output logic high_voltage_wake_pin_enable_o,
  output logic [1:0] wake_pin_pull_select_o,
  output logic [1:0] channel1_mode_o,
  output logic [1:0] channel2_mode_o,
  output logic channel1_flash_o,
  output logic channel2_flash_o
);

  logic [7:0] int_wake;
  logic [7:0] ext_wake;
  logic [7:0] pull_ctrl;
  logic [7:0] bus2;
  logic ack;
  logic [5:0] idx;
  logic wr_en;
  logic wr_int;
  logic wr_ext;
  logic wr_pull;
  logic wr_bus2;
  logic init;
  logic [7:0] next_bus2;

  // A channel that was running falls back to wake capable; an off channel stays off.
  function automatic logic [1:0] mode_on_restart(input logic [1:0] mode);
    mode_on_restart = (mode == wake_bus_pkg::MODE_OFF) ? wake_bus_pkg::MODE_OFF
                                                       : wake_bus_pkg::MODE_WAKE;
  endfunction

  // Software value merged under the writable mask, so reserved bits stay zero.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (data & wmask);
  endfunction

  assign idx = adr_i[7:2];
  assign init = rst_i | soft_reset_i;
  // A write takes effect on the edge where the master sees ack high.
  assign wr_en = cyc_i & stb_i & we_i & ack & sel_i[0];
  assign wr_int = wr_en & (idx == wake_bus_pkg::IDX_INT_WAKE);
  assign wr_ext = wr_en & (idx == wake_bus_pkg::IDX_EXT_WAKE);
  assign wr_pull = wr_en & (idx == wake_bus_pkg::IDX_PULL);
  assign wr_bus2 = wr_en & (idx == wake_bus_pkg::IDX_BUS2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= cyc_i & stb_i & ~ack;
    end
  end

  assign ack_o = ack;

  // Unmapped addresses answer with zero data; reserved bits are never stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack) begin
      unique case (idx)
        wake_bus_pkg::IDX_INT_WAKE: dat_o <= {24'h00_0000, int_wake}; // [R1]
        wake_bus_pkg::IDX_EXT_WAKE: dat_o <= {24'h00_0000, ext_wake};
        wake_bus_pkg::IDX_PULL: dat_o <= {24'h00_0000, pull_ctrl};
        wake_bus_pkg::IDX_BUS2: dat_o <= {24'h00_0000, bus2};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      int_wake <= wake_bus_pkg::RST_INT_WAKE; // [R6]
    end else if (restart_entry_i) begin
      int_wake <= int_wake & wake_bus_pkg::KEEP_INT_WAKE; // [R7]
    end else begin
      if (wr_int) begin
        int_wake <= merge(int_wake, dat_i[7:0], wake_bus_pkg::WMASK_INT_WAKE); // [R18]
      end
      if (hw_wd_stop_wr_i) begin
        int_wake[wake_bus_pkg::BIT_WD_HI] <= hw_wd_stop_val_i; // [R4]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      ext_wake <= wake_bus_pkg::RST_EXT_WAKE; // [R6]
    end else if (failsafe_entry_i) begin
      ext_wake <= wake_bus_pkg::FAILSAFE_EXT_WAKE; // [R10] [R16]
    end else if (restart_entry_i) begin
      ext_wake <= ext_wake & wake_bus_pkg::KEEP_EXT_WAKE; // [R9]
    end else if (hw_wake_pin_wr_i) begin
      ext_wake[wake_bus_pkg::BIT_WAKE_PIN] <= hw_wake_pin_val_i; // [R8]
    end else if (wr_ext) begin
      ext_wake <= merge(ext_wake, dat_i[7:0], wake_bus_pkg::WMASK_EXT_WAKE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      pull_ctrl <= wake_bus_pkg::RST_PULL;
    end else if (restart_entry_i) begin
      pull_ctrl <= pull_ctrl & wake_bus_pkg::KEEP_PULL; // [R12]
    end else if (wr_pull) begin
      pull_ctrl <= merge(pull_ctrl, dat_i[7:0], wake_bus_pkg::WMASK_PULL); // [R11]
    end
  end

  always_comb begin
    next_bus2 = bus2;
    if (restart_entry_i) begin
      next_bus2 = bus2 & wake_bus_pkg::KEEP_BUS2; // [R15]
      next_bus2[wake_bus_pkg::BIT_CH2_HI:wake_bus_pkg::BIT_CH2_LO] =
        mode_on_restart(bus2[wake_bus_pkg::BIT_CH2_HI:wake_bus_pkg::BIT_CH2_LO]);
      next_bus2[wake_bus_pkg::BIT_CH1_HI:wake_bus_pkg::BIT_CH1_LO] =
        mode_on_restart(bus2[wake_bus_pkg::BIT_CH1_HI:wake_bus_pkg::BIT_CH1_LO]);
    end else if (hw_mode_wr_i) begin
      next_bus2[wake_bus_pkg::BIT_CH2_HI:wake_bus_pkg::BIT_CH2_LO] = hw_channel2_mode_i;
      next_bus2[wake_bus_pkg::BIT_CH1_HI:wake_bus_pkg::BIT_CH1_LO] = hw_channel1_mode_i;
    end else if (wr_bus2) begin
      next_bus2 = merge(bus2, dat_i[7:0], wake_bus_pkg::WMASK_BUS2); // [R13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      bus2 <= wake_bus_pkg::RST_BUS2;
    end else if (failsafe_entry_i) begin
      // Both channels are left wake capable so a bus wake-up stays possible.
      bus2 <= (bus2 & wake_bus_pkg::KEEP_BUS2)
              | {3'h0, wake_bus_pkg::MODE_WAKE, 1'b0, wake_bus_pkg::MODE_WAKE}; // [R16]
    end else begin
      bus2 <= next_bus2;
    end
  end

  assign cyclic_wake_enable_o = int_wake[wake_bus_pkg::BIT_CYCLIC]; // [R2]
  assign battery_threshold_select_o =
    int_wake[wake_bus_pkg::BIT_THR_HI:wake_bus_pkg::BIT_THR_LO]; // [R3]
  assign watchdog_stop_disable_hi_o = int_wake[wake_bus_pkg::BIT_WD_HI]; // [R4]
  // Either stop-mode bit set deactivates the watchdog in stop mode.
  assign watchdog_stop_off_o = watchdog_stop_disable_lo_i
                               | int_wake[wake_bus_pkg::BIT_WD_HI]; // [R17]
  assign fast_battery_monitor_enable_o = int_wake[wake_bus_pkg::BIT_FAST_MON]; // [R5]
  assign high_voltage_wake_pin_enable_o = ext_wake[wake_bus_pkg::BIT_WAKE_PIN]; // [R8]
  assign wake_pin_pull_select_o =
    pull_ctrl[wake_bus_pkg::BIT_PULL_HI:wake_bus_pkg::BIT_PULL_LO]; // [R11]
  assign channel2_mode_o = bus2[wake_bus_pkg::BIT_CH2_HI:wake_bus_pkg::BIT_CH2_LO]; // [R13]
  assign channel1_mode_o = bus2[wake_bus_pkg::BIT_CH1_HI:wake_bus_pkg::BIT_CH1_LO];
  assign channel2_flash_o = bus2[wake_bus_pkg::BIT_FLASH2]; // [R14]
  assign channel1_flash_o = bus2[wake_bus_pkg::BIT_FLASH1];

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
      ((int_wake & ~wake_bus_pkg::WMASK_INT_WAKE) == 8'h00)
      && ((ext_wake & ~wake_bus_pkg::WMASK_EXT_WAKE) == 8'h00)
      && ((pull_ctrl & ~wake_bus_pkg::WMASK_PULL) == 8'h00)
      && ((bus2 & ~wake_bus_pkg::WMASK_BUS2) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R1]
    else $error("Reserved bit holds a one.");

  property p_ack_timing;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("Bus answer not given for exactly one cycle.");

  property p_soft_reset_load;
    @(posedge clk_i) disable iff (rst_i)
      soft_reset_i |=> (int_wake == 8'h01) && (ext_wake == 8'h01)
                       && fast_battery_monitor_enable_o && high_voltage_wake_pin_enable_o;
  endproperty
  a_soft_reset_load: assert property (p_soft_reset_load) // [R6]
    else $error("Soft reset did not load the wake defaults.");

  property p_restart_int;
    @(posedge clk_i) disable iff (rst_i)
      (restart_entry_i && !soft_reset_i)
      |=> (int_wake == ($past(int_wake) & 8'h71));
  endproperty
  a_restart_int: assert property (p_restart_int) // [R7]
    else $error("Restart left wrong internal wake bits.");

  property p_restart_ext;
    @(posedge clk_i) disable iff (rst_i)
      (restart_entry_i && !soft_reset_i && !failsafe_entry_i)
      |=> (ext_wake[7:1] == 7'h00) && (ext_wake[0] == $past(ext_wake[0]));
  endproperty
  a_restart_ext: assert property (p_restart_ext) // [R9]
    else $error("Restart changed the wake pin enable.");

  property p_failsafe_ext;
    @(posedge clk_i) disable iff (rst_i)
      (failsafe_entry_i && !soft_reset_i) |=> (ext_wake == 8'h01);
  endproperty
  a_failsafe_ext: assert property (p_failsafe_ext) // [R10]
    else $error("Fail-safe entry did not force wake pin enable.");

  property p_restart_pull;
    @(posedge clk_i) disable iff (rst_i)
      (restart_entry_i && !soft_reset_i)
      |=> $stable(wake_pin_pull_select_o);
  endproperty
  a_restart_pull: assert property (p_restart_pull) // [R12]
    else $error("Restart changed the pull selection.");

  property p_restart_bus2;
    @(posedge clk_i) disable iff (rst_i)
      (restart_entry_i && !soft_reset_i && !failsafe_entry_i)
      |=> $stable(channel1_flash_o) && $stable(channel2_flash_o)
          && (channel1_mode_o != 2'h2) && (channel1_mode_o != 2'h3)
          && (channel2_mode_o != 2'h2) && (channel2_mode_o != 2'h3);
  endproperty
  a_restart_bus2: assert property (p_restart_bus2) // [R15]
    else $error("Restart left a channel active or changed flash.");

  property p_failsafe_bus;
    @(posedge clk_i) disable iff (rst_i)
      (failsafe_entry_i && !soft_reset_i)
      |=> (channel1_mode_o == 2'h1) && (channel2_mode_o == 2'h1);
  endproperty
  a_failsafe_bus: assert property (p_failsafe_bus) // [R16]
    else $error("Fail-safe entry did not leave channels wake capable.");

  property p_hw_wd_stop;
    @(posedge clk_i) disable iff (rst_i)
      (hw_wd_stop_wr_i && !soft_reset_i && !restart_entry_i)
      |=> (watchdog_stop_disable_hi_o == $past(hw_wd_stop_val_i))
          && (watchdog_stop_off_o || !watchdog_stop_disable_hi_o);
  endproperty
  a_hw_wd_stop: assert property (p_hw_wd_stop) // [R4]
    else $error("Hardware update of the stop-mode bit lost.");

  property p_write_bus2;
    @(posedge clk_i) disable iff (rst_i)
      (wr_bus2 && !soft_reset_i && !restart_entry_i && !failsafe_entry_i
       && !hw_mode_wr_i)
      |=> (bus2 == ($past(dat_i[7:0]) & 8'hDB)) && !ack_o;
  endproperty
  a_write_bus2: assert property (p_write_bus2) // [R13]
    else $error("Bus control write not stored.");

  property p_read_int;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && (idx == wake_bus_pkg::IDX_INT_WAKE))
      |=> (dat_o[7:0] == $past(int_wake)) && (dat_o[31:8] == 24'h00_0000);
  endproperty
  a_read_int: assert property (p_read_int) // [R1]
    else $error("Internal wake read returned wrong data.");

  property p_write_int;
    @(posedge clk_i) disable iff (rst_i)
      (wr_int && !soft_reset_i && !restart_entry_i && !hw_wd_stop_wr_i)
      |=> (int_wake == ($past(dat_i[7:0]) & wake_bus_pkg::WMASK_INT_WAKE));
  endproperty
  a_write_int: assert property (p_write_int) // [R18]
    else $error("Internal wake write not stored under its mask.");

  property p_write_ext;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ext && !soft_reset_i && !failsafe_entry_i && !restart_entry_i && !hw_wake_pin_wr_i)
      |=> (ext_wake == ($past(dat_i[7:0]) & wake_bus_pkg::WMASK_EXT_WAKE));
  endproperty
  a_write_ext: assert property (p_write_ext) // [R18]
    else $error("External wake write not stored under its mask.");

  property p_write_pull;
    @(posedge clk_i) disable iff (rst_i)
      (wr_pull && !soft_reset_i && !restart_entry_i)
      |=> (wake_pin_pull_select_o == $past(dat_i[1:0]))
          && (pull_ctrl[7:2] == 6'h00);
  endproperty
  a_write_pull: assert property (p_write_pull) // [R11]
    else $error("Pull selection write not stored.");

  property p_hw_wake_pin;
    @(posedge clk_i) disable iff (rst_i)
      (hw_wake_pin_wr_i && !soft_reset_i && !failsafe_entry_i && !restart_entry_i)
      |=> (high_voltage_wake_pin_enable_o == $past(hw_wake_pin_val_i));
  endproperty
  a_hw_wake_pin: assert property (p_hw_wake_pin) // [R8]
    else $error("Hardware update of the wake pin enable lost.");

  property p_hw_mode;
    @(posedge clk_i) disable iff (rst_i)
      (hw_mode_wr_i && !soft_reset_i && !failsafe_entry_i && !restart_entry_i)
      |=> (channel1_mode_o == $past(hw_channel1_mode_i))
          && (channel2_mode_o == $past(hw_channel2_mode_i));
  endproperty
  a_hw_mode: assert property (p_hw_mode) // [R13]
    else $error("Hardware update of a channel mode lost.");

  property p_restart_modes;
    @(posedge clk_i) disable iff (rst_i)
      (restart_entry_i && !soft_reset_i && !failsafe_entry_i)
      |=> (channel1_mode_o == (($past(channel1_mode_o) == 2'h0) ? 2'h0 : 2'h1))
          && (channel2_mode_o == (($past(channel2_mode_o) == 2'h0) ? 2'h0 : 2'h1));
  endproperty
  a_restart_modes: assert property (p_restart_modes) // [R15]
    else $error("Restart gave a channel the wrong mode.");

  property p_failsafe_flash;
    @(posedge clk_i) disable iff (rst_i)
      (failsafe_entry_i && !soft_reset_i)
      |=> $stable(channel1_flash_o) && $stable(channel2_flash_o);
  endproperty
  a_failsafe_flash: assert property (p_failsafe_flash) // [R16]
    else $error("Fail-safe entry changed a flash mode bit.");

  property p_soft_reset_rest;
    @(posedge clk_i) disable iff (rst_i)
      soft_reset_i |=> (pull_ctrl == wake_bus_pkg::RST_PULL)
                       && (bus2 == wake_bus_pkg::RST_BUS2);
  endproperty
  a_soft_reset_rest: assert property (p_soft_reset_rest)
    else $error("Soft reset did not clear pull and bus control.");

  property p_ack_asked;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |-> $past(cyc_i) && $past(stb_i);
  endproperty
  a_ack_asked: assert property (p_ack_asked)
    else $error("Bus answer given without a request.");

endmodule

// [testbench/wb_host_model.sv]
// Host controller model that issues classic Wishbone single cycles.
module wb_host_model (
  input wire logic clk_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic ack_i,
  input wire logic [31:0] dat_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // One transfer; the request stands until ack is seen at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    do begin
      // A slave that never answers is caught by the bench's cycle limit.
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released data lines do not keep showing the last value.
    dat_o <= ~dat_o;
  endtask
endmodule

// [testbench/wake_and_bus_control_regs_bench.sv]
// Self-checking bench for the wake and bus control register bank.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module wake_and_bus_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, soft_reset, restart, failsafe, wd_wr, wd_val, pin_wr, pin_val, mode_wr, wd_lo;
  logic cyc, stb, we, ack, cyc_wake, wd_hi, wd_off, fast, pin_en, fl1, fl2;
  logic [1:0] hw_m1, hw_m2, thr, pull, m1, m2;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  wb_host_model host (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
  wake_and_bus_control_regs uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .soft_reset_i(soft_reset), .restart_entry_i(restart), .failsafe_entry_i(failsafe),
    .hw_wd_stop_wr_i(wd_wr), .hw_wd_stop_val_i(wd_val), .hw_wake_pin_wr_i(pin_wr),
    .hw_wake_pin_val_i(pin_val), .hw_mode_wr_i(mode_wr), .hw_channel1_mode_i(hw_m1),
    .hw_channel2_mode_i(hw_m2), .watchdog_stop_disable_lo_i(wd_lo),
    .cyclic_wake_enable_o(cyc_wake), .battery_threshold_select_o(thr),
    .watchdog_stop_disable_hi_o(wd_hi), .watchdog_stop_off_o(wd_off),
    .fast_battery_monitor_enable_o(fast), .high_voltage_wake_pin_enable_o(pin_en),
    .wake_pin_pull_select_o(pull), .channel1_mode_o(m1), .channel2_mode_o(m2),
    .channel1_flash_o(fl1), .channel2_flash_o(fl2));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.xfer(1'b0, a, 8'h00, v);
    `CHK("read data", e, v)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    host.xfer(1'b1, a, d, v);
    @(posedge clk);
  endtask

  // Bit order is failsafe, restart, soft reset.
  task automatic pulse(input logic [2:0] k);
    @(posedge clk);
    {failsafe, restart, soft_reset} <= k;
    @(posedge clk);
    {failsafe, restart, soft_reset} <= 3'b000;
    @(posedge clk);
  endtask

  task automatic t_reset_values();
    rd(8'h18, 8'h01);
    rd(8'h1C, 8'h01);
    rd(8'h20, 8'h00);
    rd(8'h28, 8'h00);
    rd(8'h24, 8'h00);
    `CHK("fast monitor", 1'b1, fast)
    `CHK("pin wake", 1'b1, pin_en)
  endtask

  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, 8'h8A | 8'(i << 4));
      rd(8'h18, 8'(i << 4));
      `CHK("threshold", 2'(i), thr)
      wr(8'h20, 8'hFC | 8'(i));
      rd(8'h20, 8'(i));
      `CHK("pull", 2'(i), pull)
      wr(8'h28, 8'h24 | 8'(i << 3) | 8'(i));
      rd(8'h28, 8'(i << 3) | 8'(i));
      `CHK("channel1 mode", 2'(i), m1)
      `CHK("channel2 mode", 2'(i), m2)
    end
    wr(8'h18, 8'hFF);
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'hFF);
    wr(8'h28, 8'hFF);
    rd(8'h18, 8'h75);
    rd(8'h1C, 8'h01);
    rd(8'h28, 8'hDB);
    `CHK("cyclic wake", 1'b1, cyc_wake)
    `CHK("stop disable", 1'b1, wd_hi)
    `CHK("stop off", 1'b1, wd_off)
    `CHK("fast monitor", 1'b1, fast)
    `CHK("flash", 2'b11, {fl2, fl1})
  endtask

  task automatic t_restart();
    pulse(3'b010);
    rd(8'h18, 8'h71);
    rd(8'h1C, 8'h01);
    rd(8'h20, 8'h03);
    rd(8'h28, 8'hC9);
    wr(8'h28, 8'h50);
    pulse(3'b010);
    rd(8'h28, 8'h48);
  endtask

  task automatic t_failsafe();
    wr(8'h1C, 8'h00);
    wr(8'h28, 8'h90);
    wr(8'h18, 8'h30);
    pulse(3'b100);
    rd(8'h1C, 8'h01);
    rd(8'h28, 8'h89);
    rd(8'h18, 8'h30);
  endtask

  task automatic t_hw_updates();
    @(posedge clk);
    {wd_wr, wd_val, pin_wr, pin_val, mode_wr, hw_m1, hw_m2} <= 9'b11101_10_01;
    @(posedge clk);
    {wd_wr, pin_wr, mode_wr} <= 3'b000;
    rd(8'h18, 8'h34);
    rd(8'h1C, 8'h00);
    `CHK("pin wake", 1'b0, pin_en)
    `CHK("hw modes", 4'b0110, {m2, m1})
    wr(8'h18, 8'h00);
    `CHK("stop off", 1'b0, wd_off)
    wd_lo <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    `CHK("stop off", 1'b1, wd_off)
  endtask

  initial begin
    {rst, soft_reset, restart, failsafe, wd_wr, wd_val, pin_wr, pin_val, mode_wr} = 9'h100;
    {hw_m1, hw_m2, wd_lo} = 5'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_fields();
    t_restart();
    t_failsafe();
    t_hw_updates();
    pulse(3'b001);
    rd(8'h18, 8'h01);
    rd(8'h1C, 8'h01);
    rd(8'h20, 8'h00);
    rd(8'h28, 8'h00);
    // A second reset in mid-run must bring back the same defaults.
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    finish_test();
  end
endmodule
